// [ztest_consts.svh]
// constants for the electrode test switch and converter bias block
// How it works
// R1: test disabled keeps every switch open
// R2: test enabled without connect-all closes only selected index switch
// R3: polarity choice routes to positive or negative input
// R4: controller programs bias from total conversion rate
// R5: sixteen-bit shared converter, up to 1.05 MS/s
// R6: controller sequences 32 channels plus three auxiliaries
// R7: reference on only when active and enabled
// R8: enable plus connect-all closes every switch
// R9: out-of-range index closes none; writes apply next
`ifndef ZTEST_CONSTS_SVH
`define ZTEST_CONSTS_SVH
`define OFS_TEST_CTRL 4'h0
`define OFS_TEST_SEL 4'h1
`define OFS_BUF_BIAS 4'h2
`define OFS_SEL_BIAS 4'h3
`define OFS_REF_CTRL 4'h4
`define OFS_STATUS 4'h5
`define BIT_TEST_EN 0
`define BIT_CONN_ALL 1
`define BIT_POL_SEL 2
`define BIT_REF_EN 0
`define BIT_CHIP_ACTIVE 1
`define RST_BUF_BIAS 6'h20
`define RST_SEL_BIAS 6'h28
`define CONV_RATE_MAX_KSPS 1050
`define CONV_BITS 16
`endif

// [ztest_ctrl.sv]
// electrode test switch control and converter bias registers
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ztest_consts.svh"
`default_nettype none
module ztest_ctrl #(
	parameter int NCH = 32,
	parameter bit DUAL_INPUT = 1'b1
) (
	input wire logic core_clk_i, // core clock
	input wire logic nrst_i, // async reset, active low
	input wire logic clk_en_i, // clock enable
	input wire logic [3:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after read
	output logic [NCH-1:0] pos_close_o, // positive input switch closures
	output logic [NCH-1:0] neg_close_o, // negative input switch closures
	output logic [5:0] buffer_bias_o, // converter buffer bias code
	output logic [5:0] selector_current_setting_o, // selector bias code
	output logic ref_on_o // converter reference enable
);
	////////////////////////////////////////////////////////////////////////////
	logic [2:0] test_ctrl_reg;
	logic [4:0] test_sel_reg;
	logic [5:0] buf_bias_reg;
	logic [5:0] sel_bias_reg;
	logic [1:0] ref_ctrl_reg;
	// one address comparison shared by every strobe decode
	function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] ofs);
	begin
		return a == ofs;
	end
	endfunction
	// true when the index names an amplifier that this build has
	function automatic logic idx_present(input logic [4:0] i);
	begin
		return 32'(i) < NCH;
	end
	endfunction
	wire logic wr_ctrl = wr_i && addr_hit(addr_i, `OFS_TEST_CTRL);
	wire logic wr_sel = wr_i && addr_hit(addr_i, `OFS_TEST_SEL);
	wire logic wr_buf = wr_i && addr_hit(addr_i, `OFS_BUF_BIAS);
	wire logic wr_sbias = wr_i && addr_hit(addr_i, `OFS_SEL_BIAS);
	wire logic wr_ref = wr_i && addr_hit(addr_i, `OFS_REF_CTRL);
	// one short block per register; an unmapped address writes nothing
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			test_ctrl_reg <= 3'h0;
		else if (clk_en_i && wr_ctrl)
			test_ctrl_reg <= wdata_i[2:0];
	end
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			test_sel_reg <= 5'h00;
		else if (clk_en_i && wr_sel)
			test_sel_reg <= wdata_i[4:0];
	end
	// bias codes are stored as written; the rate table is software's job
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			buf_bias_reg <= `RST_BUF_BIAS;
		else if (clk_en_i && wr_buf)
			buf_bias_reg <= wdata_i[5:0];
	end
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sel_bias_reg <= `RST_SEL_BIAS;
		else if (clk_en_i && wr_sbias)
			sel_bias_reg <= wdata_i[5:0];
	end
	// reference enable and chip-active flags; both must be set
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ref_ctrl_reg <= 2'h0;
		else if (clk_en_i && wr_ref)
			ref_ctrl_reg <= wdata_i[1:0];
	end
	////////////////////////////////////////////////////////////////////////////
	ztest_pkg::test_mode_t mode;
	wire logic pol = DUAL_INPUT & test_ctrl_reg[`BIT_POL_SEL];
	assign mode = !test_ctrl_reg[`BIT_TEST_EN] ? ztest_pkg::TEST_OFF : // R1
		test_ctrl_reg[`BIT_CONN_ALL] ? ztest_pkg::TEST_ALL : ztest_pkg::TEST_ONE; // R8 R2
	wire logic [NCH-1:0] pos_next;
	wire logic [NCH-1:0] neg_next;
	ztest_switch_decode #(.NCH(NCH)) u_dec (
		.mode_i(mode),
		.index_i(test_sel_reg),
		.pol_i(pol),
		.pos_close_o(pos_next),
		.neg_close_o(neg_next)
	);
	wire logic ref_next = ref_ctrl_reg[`BIT_REF_EN] & ref_ctrl_reg[`BIT_CHIP_ACTIVE]; // R7
	logic [7:0] rdata_next;
	always_comb
	begin
		case (addr_i)
			`OFS_TEST_CTRL: rdata_next = {5'h00, test_ctrl_reg};
			`OFS_TEST_SEL: rdata_next = {3'h0, test_sel_reg};
			`OFS_BUF_BIAS: rdata_next = {2'h0, buf_bias_reg};
			`OFS_SEL_BIAS: rdata_next = {2'h0, sel_bias_reg};
			`OFS_REF_CTRL: rdata_next = {6'h00, ref_ctrl_reg};
			`OFS_STATUS: rdata_next = {5'h00, ref_on_o, |neg_close_o, |pos_close_o};
			default: rdata_next = 8'h00;
		endcase
	end
	// outputs registered: settings apply the cycle after the write lands
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rdata_o <= 8'h00;
			pos_close_o <= '0;
			neg_close_o <= '0;
			buffer_bias_o <= `RST_BUF_BIAS;
			selector_current_setting_o <= `RST_SEL_BIAS;
			ref_on_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			rdata_o <= rd_i ? rdata_next : 8'h00;
			pos_close_o <= pos_next; // R9
			neg_close_o <= neg_next;
			buffer_bias_o <= buf_bias_reg; // R4 R5
			selector_current_setting_o <= sel_bias_reg;
			ref_on_o <= ref_next; // R7
		end
	end
	////////////////////////////////////////////////////////////////////////////
	wire logic [NCH-1:0] all_close = pos_close_o | neg_close_o;
	sequence en_written_s;
		clk_en_i && wr_ctrl && wdata_i[`BIT_TEST_EN] && !wdata_i[`BIT_CONN_ALL];
	endsequence
	off_open_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R1
		clk_en_i && wr_ctrl && !wdata_i[`BIT_TEST_EN] ##1 clk_en_i |=> all_close == '0)
		else $error("switch closed while test disabled");
	one_closed_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R2
		$past(mode) == ztest_pkg::TEST_ONE && 32'($past(test_sel_reg)) < NCH && $past(clk_en_i)
		|-> $onehot(all_close) && all_close[$past(test_sel_reg)])
		else $error("selected switch not sole closure");
	pol_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R3
		(pos_close_o & neg_close_o) == '0)
		else $error("both polarities closed");
	ref_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		ref_on_o |-> $past(ref_ctrl_reg) == 2'h3)
		else $error("reference on without enable");
	all_closed_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R8
		$past(mode) == ztest_pkg::TEST_ALL && $past(clk_en_i) |-> all_close == '1)
		else $error("connect all not closing every switch");
	bad_index_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		$past(mode) == ztest_pkg::TEST_ONE && 32'($past(test_sel_reg)) >= NCH
		&& $past(clk_en_i) |-> all_close == '0)
		else $error("absent channel closed a switch");
	write_apply_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		en_written_s ##1 clk_en_i |=> all_close != '0 || !idx_present($past(test_sel_reg)))
		else $error("enable write not applied");
	bias_follow_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R4
		clk_en_i && wr_sbias ##1 clk_en_i |=> selector_current_setting_o == $past(wdata_i[5:0], 2))
		else $error("selector bias not applied");
	////////////////////////////////////////////////////////////////////////////
	// multi-step bus behaviours
	sequence buf_written_s;
		clk_en_i && wr_buf;
	endsequence
	sequence sel_read_s;
		clk_en_i && rd_i && addr_hit(addr_i, `OFS_TEST_SEL);
	endsequence
	sequence status_read_s;
		clk_en_i && rd_i && addr_hit(addr_i, `OFS_STATUS);
	endsequence
	buf_follow_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R4
		buf_written_s ##1 clk_en_i |=> buffer_bias_o == $past(wdata_i[5:0], 2))
		else $error("buffer bias not applied");
	// closures follow the settings sampled one edge earlier
	off_state_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R1
		$past(mode) == ztest_pkg::TEST_OFF && $past(clk_en_i) |-> all_close == '0)
		else $error("switch closed in test off state");
	pos_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R3
		!$past(pol) && $past(clk_en_i) |-> neg_close_o == '0)
		else $error("negative input closed with positive polarity");
	neg_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R3
		$past(pol) && $past(clk_en_i) |-> pos_close_o == '0)
		else $error("positive input closed with negative polarity");
	ref_on_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		$past(ref_ctrl_reg) == 2'h3 && $past(clk_en_i) |-> ref_on_o)
		else $error("reference off although enabled and active");
	ref_off_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		$past(ref_ctrl_reg) != 2'h3 && $past(clk_en_i) |-> !ref_on_o)
		else $error("reference on without both flags");
	// register file: writes land at once; unmapped or frozen cycles change nothing
	ctrl_lands_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		clk_en_i && wr_ctrl |=> test_ctrl_reg == $past(wdata_i[2:0]))
		else $error("test control write lost");
	sel_lands_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		clk_en_i && wr_sel |=> test_sel_reg == $past(wdata_i[4:0]))
		else $error("index write lost");
	buf_lands_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R4
		clk_en_i && wr_buf |=> buf_bias_reg == $past(wdata_i[5:0]))
		else $error("buffer bias write lost");
	ref_lands_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		clk_en_i && wr_ref |=> ref_ctrl_reg == $past(wdata_i[1:0]))
		else $error("reference control write lost");
	unmapped_write_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		clk_en_i && wr_i && addr_i > `OFS_REF_CTRL |=> $stable(test_ctrl_reg) && $stable(test_sel_reg)
		&& $stable(buf_bias_reg) && $stable(sel_bias_reg) && $stable(ref_ctrl_reg))
		else $error("unmapped write changed a register");
	freeze_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		!clk_en_i |=> $stable(pos_close_o) && $stable(neg_close_o) && $stable(ref_on_o)
		&& $stable(rdata_o) && $stable(buffer_bias_o))
		else $error("output moved while clock enable low");
	// read port answers for one cycle only
	sel_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R2
		sel_read_s |=> rdata_o == {3'h0, $past(test_sel_reg)})
		else $error("index read back wrong");
	status_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		status_read_s |=> rdata_o[2] == $past(ref_on_o))
		else $error("status reference bit wrong");
	rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		clk_en_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read data outside its cycle");
endmodule
`default_nettype wire

// [ztest_ctrl_tb_top.sv]
// self-checking bench for the electrode test switch control block
`timescale 1ns/1ps
`default_nettype none
`include "ztest_consts.svh"
module ztest_ctrl_tb_top;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, rv;
	logic wr, rd, ref_on;
	logic [31:0] pos, neg;
	logic [5:0] buf_bias, sel_bias;
	logic clk_en = 1'b1;
	logic [11:0] row;
	int bad_count = 0;
	int compares = 0;
	always #5 core_clk_i = ~core_clk_i;
	ztest_ctrl u_ztest_ctrl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.pos_close_o(pos), .neg_close_o(neg), .buffer_bias_o(buf_bias),
		.selector_current_setting_o(sel_bias), .ref_on_o(ref_on));
	ztest_host_model u_ztest_host_model (.core_clk_i(core_clk_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
	begin
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	end
	endtask
	task automatic stop_test();
	begin
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// effect lands one edge after the write is taken; the task waits two
	task automatic wr_set(input logic [3:0] a, input logic [7:0] d);
	begin
		u_ztest_host_model.wr_reg(a, d);
		repeat (2) @(posedge core_clk_i);
		#1;
	end
	endtask
	task automatic sw(input logic [31:0] ep, input logic [31:0] en);
	begin
		chk("pos_close", pos, ep);
		chk("neg_close", neg, en);
	end
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		#1;
		chk("buf_bias", 32'(buf_bias), 32'(`RST_BUF_BIAS));
		chk("sel_bias", 32'(sel_bias), 32'(`RST_SEL_BIAS));
		chk("ref_on", 32'(ref_on), 32'h0);
		wr_set(`OFS_TEST_SEL, 8'h05);
		sw(32'h0, 32'h0);
		wr_set(`OFS_TEST_CTRL, 8'h01);
		for (int i = 0; i < 32; i++)
		begin
			wr_set(`OFS_TEST_SEL, 8'(i));
			sw(32'h1 << i, 32'h0);
		end
		wr_set(`OFS_TEST_CTRL, 8'h05);
		sw(32'h0, 32'h80000000);
		wr_set(`OFS_TEST_CTRL, 8'h03);
		sw(32'hffffffff, 32'h0);
		wr_set(`OFS_TEST_CTRL, 8'h07);
		sw(32'h0, 32'hffffffff);
		wr_set(`OFS_TEST_CTRL, 8'h02);
		sw(32'h0, 32'h0);
		for (int v = 0; v < 4; v++)
		begin
			wr_set(`OFS_REF_CTRL, 8'(v));
			chk("ref_on", 32'(ref_on), 32'(v == 3));
		end
		for (int r = 0; r < 9; r++)
		begin
			u_ztest_host_model.set_rate(r);
			row = u_ztest_host_model.bias_row(r);
			repeat (2) @(posedge core_clk_i);
			#1;
			chk("buf_bias", 32'(buf_bias), 32'(row[11:6]));
			chk("sel_bias", 32'(sel_bias), 32'(row[5:0]));
		end
		// a write while the clock enable is low must be dropped
		@(posedge core_clk_i);
		clk_en <= 1'b0;
		wr_set(`OFS_TEST_CTRL, 8'h03);
		@(posedge core_clk_i);
		clk_en <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		sw(32'h0, 32'h0);
		u_ztest_host_model.rd_reg(`OFS_TEST_CTRL, rv);
		chk("ctrl", 32'(rv), 32'h02);
		u_ztest_host_model.rd_reg(`OFS_TEST_SEL, rv);
		chk("index", 32'(rv), 32'h1f);
		u_ztest_host_model.rd_reg(`OFS_STATUS, rv);
		chk("status", 32'(rv), 32'h04);
		@(posedge core_clk_i);
		#1;
		chk("rdata_idle", 32'(rdata), 32'h0);
		u_ztest_host_model.rd_reg(4'hf, rv);
		chk("unmapped", 32'(rv), 32'h0);
		// second reset mid-run puts every setting back
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chk("buf_bias", 32'(buf_bias), 32'(`RST_BUF_BIAS));
		chk("sel_bias", 32'(sel_bias), 32'(`RST_SEL_BIAS));
		chk("ref_on", 32'(ref_on), 32'h0);
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		u_ztest_host_model.rd_reg(`OFS_TEST_SEL, rv);
		chk("index", 32'(rv), 32'h00);
		stop_test();
	end
	// a hang ends the run the normal way
	initial
	begin
		#20000;
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire

// [ztest_host_model.sv]
// bus master model that programs the test and bias registers
`timescale 1ns/1ps
`default_nettype none
`include "ztest_consts.svh"
module ztest_host_model (
	input wire logic core_clk_i, // core clock
	input wire logic [7:0] rdata_i, // read data
	output logic [3:0] addr_o, // address
	output logic [7:0] wdata_o, // write data
	output logic wr_o, // write strobe
	output logic rd_o // read strobe
);
	// bias rows, lowest total rate first
	// each row packs {buffer, selector}
	function automatic logic [11:0] bias_row(input int r);
	begin
		case (r)
			0: bias_row = {6'h20, 6'h28};
			1: bias_row = {6'h10, 6'h28};
			2: bias_row = {6'h08, 6'h28};
			3: bias_row = {6'h08, 6'h20};
			4: bias_row = {6'h08, 6'h1a};
			5: bias_row = {6'h04, 6'h12};
			6: bias_row = {6'h03, 6'h10};
			7: bias_row = {6'h03, 6'h07};
			default: bias_row = {6'h02, 6'h04};
		endcase
	end
	endfunction
	initial
	begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge core_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
	end
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
	begin
		@(posedge core_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge core_clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	end
	endtask
	task automatic set_rate(input int r);
		logic [11:0] row;
	begin
		row = bias_row(r);
		wr_reg(`OFS_BUF_BIAS, {2'h0, row[11:6]});
		wr_reg(`OFS_SEL_BIAS, {2'h0, row[5:0]});
	end
	endtask
endmodule
`default_nettype wire

// [ztest_pkg.sv]
// types shared by the electrode test block
package ztest_pkg;
	typedef enum logic [1:0] {
		TEST_OFF = 2'b00,
		TEST_ONE = 2'b01,
		TEST_ALL = 2'b10
	} test_mode_t;
endpackage

// [ztest_switch_decode.sv]
// decoder from test settings to switch closures
`timescale 1ns/1ps
`default_nettype none
module ztest_switch_decode #(
	parameter int NCH = 32
) (
	input wire ztest_pkg::test_mode_t mode_i, // decoded test mode
	input wire logic [4:0] index_i, // selected electrode index
	input wire logic pol_i, // polarity choice
	output logic [NCH-1:0] pos_close_o, // positive input switches
	output logic [NCH-1:0] neg_close_o // negative input switches
);
	wire logic [NCH-1:0] one_hot;
	wire logic [NCH-1:0] closes;
	// index beyond the channel count decodes to nothing
	assign one_hot = (32'(index_i) < NCH) ? (NCH'(1) << index_i) : '0; // R9
	assign closes = (mode_i == ztest_pkg::TEST_ALL) ? '1 : // R8
		(mode_i == ztest_pkg::TEST_ONE) ? one_hot : '0; // R1 R2
	assign pos_close_o = pol_i ? '0 : closes; // R3
	assign neg_close_o = pol_i ? closes : '0; // R3
endmodule
`default_nettype wire
